// *** testbench/qdcs_core_asserts.sv ***
// Port checks for the divider configuration store.
// Assumes one clock domain; bound to every qdcs_core instance.
`timescale 1ns/10ps
`include "qdcs_defines.svh"
module qdcs_core_asserts
#(
   parameter logic XTAL_IS_100M = 1'b0
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic outputDriveEnable,
   input wire logic freq_select_hi,
   input wire logic freq_select_lo,
   input wire logic serialClk,
   input wire logic serial_data_pin_out,
   input wire logic serial_data_pin_oe,
   input wire logic diff_clock_out_pair_oe,
   input wire logic [`QDCS_INT_W:0] activeFeedbackRatio,
   input wire logic [1:0] activeSetIndex,
   input wire logic [16:0] crystalReferenceKhz
);
   // ====
   // Helpers
   // Both counters saturate, so checks wait until the select path has settled.
   logic [1:0] pinPair;
   logic [2:0] upCnt;
   logic [2:0] pinAge;
   assign pinPair = {freq_select_hi, freq_select_lo};
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         upCnt <= 3'h0;
         pinAge <= 3'h0;
      end
      else
      begin
         upCnt <= upCnt + {2'h0, upCnt != 3'h7};
         pinAge <= $changed(pinPair) ? 3'h0 : pinAge + {2'h0, pinAge != 3'h7};
      end
   end
   // ====
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_pins_held;
      $stable(pinPair) [*5];
   endsequence
   a_oe_follows_pin: assert property (diff_clock_out_pair_oe == outputDriveEnable)
      else $error("Pair enable differs from its pin.");
   a_oe_unclocked: assert property (@(negedge clk)
      diff_clock_out_pair_oe == outputDriveEnable)
      else $error("Pair enable differs between edges.");
   a_select_applied: assert property (s_pins_held ##0 (upCnt == 3'h7)
      |-> activeSetIndex == pinPair)
      else $error("Active set does not match the select pins.");
   a_select_steady: assert property (upCnt == 3'h7 && pinAge > 3'h4
      |-> $stable(activeSetIndex))
      else $error("Active set moved without a pin change.");
   a_ref_khz: assert property (upCnt != 3'h0 |-> crystalReferenceKhz ==
      (XTAL_IS_100M ? 17'(`QDCS_XTAL_KHZ_B) : 17'(`QDCS_XTAL_KHZ_A)))
      else $error("Wrong reference frequency.");
   a_sda_open_drain: assert property (serial_data_pin_out == 1'b0)
      else $error("Data pin driven high.");
   a_sda_after_fall: assert property ($rose(serial_data_pin_oe) |->
      !$past(serialClk, 2) || !$past(serialClk, 3) || !$past(serialClk, 4))
      else $error("Readback bit changed without a clock fall.");
   a_ratio_dither: assert property (upCnt == 3'h7 && pinAge == 3'h7 |->
      activeFeedbackRatio - $past(activeFeedbackRatio) + 8'h01 <= 8'h02)
      else $error("Feedback ratio jumped by more than one.");
endmodule

bind qdcs_core qdcs_core_asserts #(.XTAL_IS_100M(XTAL_IS_100M)) coreChecks
(
   .clk(clk), .srst(srst), .outputDriveEnable(outputDriveEnable),
   .freq_select_hi(freq_select_hi), .freq_select_lo(freq_select_lo),
   .serialClk(serialClk), .serial_data_pin_out(serial_data_pin_out),
   .serial_data_pin_oe(serial_data_pin_oe), .diff_clock_out_pair_oe(diff_clock_out_pair_oe),
   .activeFeedbackRatio(activeFeedbackRatio), .activeSetIndex(activeSetIndex),
   .crystalReferenceKhz(crystalReferenceKhz)
);

// *** testbench/qdcs_serial_host.sv ***
// Serial host model: frames of 48 bits, 32 ns clock, idle high.
// Assumes the bench resolves the open-drain data line with a pullup.
`timescale 1ns/10ps
module qdcs_serial_host
(
   output logic serialClk,
   output logic hostData,
   input wire logic lineLevel
);
   initial
   begin
      serialClk = 1'b1;
      hostData = 1'b1;
   end
   // Readback is sampled just before the next fall, where the bit is surely settled.
   task automatic xfer(input logic rd, input logic [1:0] idx, input logic [39:0] wr,
      output logic [39:0] got);
      logic [47:0] frame;
      frame = {5'h00, rd, idx, wr};
      got = 40'h0;
      for (int i = 47; i >= 0; i--)
      begin
         serialClk = 1'b0;
         hostData = (rd && i < 40) ? 1'b1 : frame[i];
         #16 serialClk = 1'b1;
         #15;
         if (i < 40)
            got[i] = lineLevel;
         #1;
      end
      hostData = 1'b1;
      #32;
   endtask
endmodule

// *** testbench/tb_quad_divider_config_select.sv ***
// Self-checking bench for the divider configuration store.
// Assumes the serial host model and the bound checker are compiled first.
`timescale 1ns/10ps
`include "qdcs_defines.svh"
module tb_quad_divider_config_select
   import qdcs_pkg::*;
;
   localparam logic [33:0] PRESET [4] = '{`QDCS_PRESET0, `QDCS_PRESET1,
      `QDCS_PRESET2, `QDCS_PRESET3};
   logic clk, srst, outputDriveEnable, fsHi, fsLo, serialClk, hostData, lineLevel;
   logic sdaOut, sdaOe, synthClk, pairP, pairN, pairOe;
   logic [1:0] preDiv, setIdx, cur, j;
   logic [7:0] ratio;
   logic [6:0] postDiv;
   logic [16:0] xtalKhz;
   logic [33:0] store [4];
   logic [39:0] got;
   int fail_count = 0;
   int n_tests = 0;
   int cnt, e, pr, nb;
   logic lastP;
   qdcs_set_t s;
   assign lineLevel = hostData & (sdaOe ? sdaOut : 1'b1);
   qdcs_core dut
   (
      .clk(clk), .srst(srst), .outputDriveEnable(outputDriveEnable),
      .freq_select_hi(fsHi), .freq_select_lo(fsLo), .serialClk(serialClk),
      .serial_data_pin_in(lineLevel), .serial_data_pin_out(sdaOut),
      .serial_data_pin_oe(sdaOe), .synthClockIn(synthClk),
      .diff_clock_out_pair_p(pairP), .diff_clock_out_pair_n(pairN),
      .diff_clock_out_pair_oe(pairOe), .activePreDiv(preDiv),
      .activeFeedbackRatio(ratio), .activePostDiv(postDiv),
      .activeSetIndex(setIdx), .crystalReferenceKhz(xtalKhz)
   );
   qdcs_serial_host host (.serialClk(serialClk), .hostData(hostData), .lineLevel(lineLevel));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      synthClk = 1'b0;
      forever #3.1 synthClk = ~synthClk;
   end
   // ====
   // Tasks
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("Mismatches %0d, checks %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic readAll;
      for (int i = 0; i < 4; i++)
      begin
         host.xfer(1'b1, 2'(i), 40'h0, got);
         chk(got[33:0], store[i]);
      end
   endtask
   task automatic pick(input logic [1:0] idx);
      logic [7:0] ein;
      @(negedge clk);
      {fsHi, fsLo} = idx;
      cur = idx;
      repeat (8) @(negedge clk);
      s = store[idx];
      ein = {1'b0, s.feedbackInteger};
      chk(setIdx, idx);
      chk(preDiv, s.preDiv);
      chk(postDiv, s.postDiv);
      chk(ratio - ein < 8'h02 ? ein : ratio, ein);
   endtask
   // ====
   // Main sequence
   initial
   begin
      void'($urandom(32'h63b5));
      srst = 1'b1;
      outputDriveEnable = 1'b1;
      {fsHi, fsLo} = 2'($urandom);
      cur = {fsHi, fsLo};
      store = PRESET;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      readAll();
      pick(cur);
      chk(xtalKhz, `QDCS_XTAL_KHZ_A);
      for (int i = 0; i < 4; i++)
         pick(2'(i));
      repeat (16)
      begin
         @(negedge clk);
         #1 outputDriveEnable = 1'($urandom);
         #0.5 chk(pairOe, outputDriveEnable);
      end
      @(negedge clk);
      outputDriveEnable = 1'b1;
      for (int k = 0; k < 6; k++)
      begin
         j = cur + 2'h1 + 2'($urandom_range(2));
         s.preDiv = 2'($urandom_range(3, 1));
         s.feedbackInteger = 7'($urandom_range(126, 24));
         s.feedbackFraction = 18'($urandom);
         s.postDiv = k == 0 ? 7'h03 : k == 1 ? 7'h7e : k == 2 ? 7'h02 :
            7'($urandom_range(126, 3));
         store[j] = s;
         host.xfer(1'b0, j, {6'h00, s}, got);
         pick(j);
         cnt = 0;
         pr = 0;
         nb = 0;
         lastP = pairP;
         repeat (1024)
         begin
            @(negedge clk);
            cnt += int'(ratio == {1'b0, s.feedbackInteger} + 8'h01);
            pr += int'(pairP !== lastP);
            lastP = pairP;
            nb += int'(pairN !== ~pairP);
         end
         e = (1024 * int'(s.feedbackFraction) + 131072) >> 18;
         chk((cnt - e + 1) inside {[0:2]} ? e : cnt, e);
         // At most 661 synth rises fit in the window; each output period takes
         // one post divider count of them, so the toggle count is bounded.
         chk(pr >= 1 && pr <= 2 * (661 / int'(s.postDiv) + 1), 1'b1);
         chk(nb, 0);
      end
      readAll();
      @(negedge clk);
      srst = 1'b1;
      store = PRESET;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      readAll();
      pick(2'($urandom));
      test_done();
   end
   initial
   begin
      #400000;
      fail_count++;
      test_done();
   end
endmodule

// *** verilog/qdcs_core.sv ***
// Quad divider configuration store with selection and serial host access.
// Assumes serialClk, serialData and the select pins are asynchronous to clk,
// and that the output enable acts combinationally on the pad drivers.
`timescale 1ns/10ps
`include "qdcs_defines.svh"

// Summary of operation
// - Output enable low tristates clock pair
// - Output enable acts without any clock
// - Four independent divider sets, index 0-3
// - Select pins binary index the active set
// - Reset loads factory presets into sets
// - Sets are volatile, presets restored
// - Host may write any set
// - Host may read back every set
// - Select change switches dividers at once
// - Fields are 2, 7, 18, 7 bits
// - Frequency follows pre, post, integer, fraction
// - Reference is 114.285 or 100 MHz
// - Fraction realised by delta-sigma modulator
module qdcs_core
   import qdcs_pkg::*;
#(
   parameter int NUM_SETS = `QDCS_NUM_SETS,
   parameter logic XTAL_IS_100M = 1'b0
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic outputDriveEnable,
   input wire logic freq_select_hi,
   input wire logic freq_select_lo,
   input wire logic serialClk,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   input wire logic synthClockIn,
   output logic diff_clock_out_pair_p,
   output logic diff_clock_out_pair_n,
   output logic diff_clock_out_pair_oe,
   output logic [`QDCS_PRE_W-1:0] activePreDiv,
   output logic [`QDCS_INT_W:0] activeFeedbackRatio,
   output logic [`QDCS_POST_W-1:0] activePostDiv,
   output logic [1:0] activeSetIndex,
   output logic [16:0] crystalReferenceKhz
);
   qdcs_set_t sets [NUM_SETS];
   qdcs_set_t activeSet;
   qdcs_state_t state;
   qdcs_dsm_if dsmBus();

   logic [1:0] selMeta;
   logic [1:0] selSync;
   logic [1:0] sclMeta;
   logic [1:0] sclSync;
   logic sdaMeta;
   logic sdaSync;
   logic [7:0] shiftIn;
   logic [2:0] bitCount;
   logic [2:0] byteCount;
   logic [1:0] targetSet;
   logic readMode;
   logic [39:0] dataAcc;
   logic [40:0] readShift;
   logic sdaOut;
   logic sdaOe;
   logic [`QDCS_POST_W-1:0] postCount;
   logic outToggle;
   logic [1:0] synthMeta;
   logic [1:0] synthSync;

   wire logic [1:0] freq_select_pair;
   wire logic sclRise;
   wire logic sclFall;
   wire logic byteDone;
   wire logic frameDone;
   wire logic synthRise;
   wire logic [7:0] nextByte;
   wire logic [`QDCS_POST_W-1:0] postLimit;

   // ========================================================================
   // Input synchronisers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // Reset to the idle pin levels, so that no false edge follows reset.
         selMeta <= '0;
         selSync <= '0;
         sclMeta <= '1;
         sclSync <= '1;
         sdaMeta <= 1'b1;
         sdaSync <= 1'b1;
         synthMeta <= '0;
         synthSync <= '0;
      end
      else
      begin
         selMeta <= {freq_select_hi, freq_select_lo};
         selSync <= selMeta;
         sclMeta <= {sclMeta[0], serialClk};
         sclSync <= {sclSync[0], sclMeta[1]};
         sdaMeta <= serial_data_pin_in;
         sdaSync <= sdaMeta;
         synthMeta <= {synthMeta[0], synthClockIn};
         synthSync <= {synthSync[0], synthMeta[1]};
      end
   end

   // ========================================================================
   // Set selection
   // Decoding is purely combinational on the synchronised pins, so a new index reaches the pre and post
   // dividers on the next edge and the feedback ratio one edge later, with no command needed.
   assign freq_select_pair = selSync;
   assign activeSet = sets[freq_select_pair];
   assign dsmBus.feedbackInteger = activeSet.feedbackInteger;
   assign dsmBus.feedbackFraction = activeSet.feedbackFraction;

   qdcs_dsm u_dsm
   (
      .clk(clk),
      .srst(srst),
      .dsmPort(dsmBus)
   );

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         activePreDiv <= '0;
         activeFeedbackRatio <= '0;
         activePostDiv <= '0;
         activeSetIndex <= '0;
         crystalReferenceKhz <= '0;
      end
      else
      begin
         activePreDiv <= activeSet.preDiv;
         activeFeedbackRatio <= dsmBus.divideRatio;
         activePostDiv <= activeSet.postDiv;
         activeSetIndex <= freq_select_pair;
         crystalReferenceKhz <= XTAL_IS_100M ? 17'(`QDCS_XTAL_KHZ_B)
                                             : 17'(`QDCS_XTAL_KHZ_A);
      end
   end

   // ========================================================================
   // Post divider on the synthesized clock
   // The core clock oversamples the VCO model, so only slow synth inputs are
   // divided faithfully; this stands in for the analog output divider.
   assign synthRise = synthSync[0] & ~synthSync[1];
   assign postLimit = (activeSet.postDiv > 7'h01) ? activeSet.postDiv : 7'h02;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         postCount <= '0;
         outToggle <= 1'b0;
      end
      else if (synthRise)
      begin
         if (postCount >= postLimit - 7'h01)
         begin
            postCount <= '0;
         end
         else
         begin
            postCount <= postCount + 7'h01;
         end
         if (postCount == '0 || postCount == (postLimit >> 1))
         begin
            outToggle <= ~outToggle;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      diff_clock_out_pair_p <= outToggle;
      diff_clock_out_pair_n <= ~outToggle;
   end

   // The pad enable bypasses every flip-flop: it must act with no clock.
   assign diff_clock_out_pair_oe = outputDriveEnable;

   // ========================================================================
   // Serial host access
   // A frame is one address byte then five data bytes, MSB first, sampled on
   // serial clock rises; read data shifts out on falls. Frame ends on count.
   assign sclRise = sclSync[0] & ~sclSync[1];
   assign sclFall = ~sclSync[0] & sclSync[1];
   assign nextByte = {shiftIn[6:0], sdaSync};
   assign byteDone = sclRise && bitCount == 3'h7;
   assign frameDone = byteDone && byteCount == `QDCS_FRAME_BYTES - 3'h1;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= QDCS_IDLE;
         shiftIn <= '0;
         bitCount <= '0;
         byteCount <= '0;
         targetSet <= '0;
         readMode <= 1'b0;
         dataAcc <= '0;
         readShift <= '0;
      end
      else
      begin
         if (sclRise)
         begin
            shiftIn <= nextByte;
            bitCount <= bitCount + 3'h1;
         end
         if (byteDone)
         begin
            byteCount <= frameDone ? 3'h0 : byteCount + 3'h1;
         end
         unique case (state)
            QDCS_IDLE:
            begin
               if (sclRise)
               begin
                  state <= QDCS_ADDR;
               end
            end
            QDCS_ADDR:
            begin
               if (byteDone)
               begin
                  targetSet <= nextByte[1:0];
                  readMode <= nextByte[2];
                  // A leading released bit covers the gap up to the first fall,
                  // so bit 39 then stands for a whole bit time like the others.
                  readShift <= {7'h40, sets[nextByte[1:0]]};
                  state <= nextByte[2] ? QDCS_RDBK : QDCS_DATA;
               end
            end
            QDCS_DATA:
            begin
               if (byteDone)
               begin
                  dataAcc <= {dataAcc[31:0], nextByte};
               end
               if (frameDone)
               begin
                  state <= QDCS_IDLE;
               end
            end
            QDCS_RDBK:
            begin
               if (sclFall)
               begin
                  readShift <= {readShift[39:0], 1'b0};
               end
               if (frameDone)
               begin
                  state <= QDCS_IDLE;
               end
            end
         endcase
      end
   end

   // ========================================================================
   // Configuration storage
   // Plain flip-flops: presets return on every reset, nothing survives it.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SETS; gi++)
      begin : g_set
         localparam logic [`QDCS_SET_W-1:0] PRESET =
            (gi == 0) ? `QDCS_PRESET0 : (gi == 1) ? `QDCS_PRESET1 :
            (gi == 2) ? `QDCS_PRESET2 : `QDCS_PRESET3;
         wire logic writeHit;
         assign writeHit = frameDone && state == QDCS_DATA && !readMode &&
                           targetSet == 2'(gi);
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               sets[gi] <= PRESET;
            end
            else if (writeHit)
            begin
               sets[gi] <= qdcs_set_t'({dataAcc[25:0], nextByte});
            end
         end
      end
   endgenerate

   // Drive the data pin only while reading; open drain, low when bit is 0.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sdaOut <= 1'b0;
         sdaOe <= 1'b0;
      end
      else
      begin
         sdaOut <= 1'b0;
         sdaOe <= state == QDCS_RDBK && !readShift[40];
      end
   end

   assign serial_data_pin_out = sdaOut;
   assign serial_data_pin_oe = sdaOe;
endmodule

// *** verilog/qdcs_defines.svh ***
// Constants for the quad divider configuration select block.
// Assumes inclusion by qdcs_pkg, the design modules and the testbench files.
`ifndef QDCS_DEFINES_SVH
`define QDCS_DEFINES_SVH

// ==========================================================================
// Field widths of one configuration set
`define QDCS_PRE_W 2
`define QDCS_INT_W 7
`define QDCS_FRAC_W 18
`define QDCS_POST_W 7
`define QDCS_SET_W 34
`define QDCS_NUM_SETS 4

// ==========================================================================
// Factory preset words, one per set, packed {pre, int, frac, post}
`define QDCS_PRESET0 34'h1_6400_0008
`define QDCS_PRESET1 34'h1_6400_0006
`define QDCS_PRESET2 34'h1_6400_0004
`define QDCS_PRESET3 34'h1_6400_0002

// ==========================================================================
// Crystal reference choices in kHz
`define QDCS_XTAL_KHZ_A 114285
`define QDCS_XTAL_KHZ_B 100000

// ==========================================================================
// Serial host framing: address byte {0,0,0,0,0,rw,set[1:0]} then five data bytes
`define QDCS_FRAME_BYTES 3'h6
`define QDCS_DSM_ACC_W 18

`endif

// *** verilog/qdcs_dsm.sv ***
// First order delta-sigma modulator for the fractional feedback divider.
// Assumes the active set arrives on the same clock as clk.
`timescale 1ns/10ps
`include "qdcs_defines.svh"

module qdcs_dsm
   import qdcs_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   qdcs_dsm_if.dsm dsmPort
);
   logic [`QDCS_DSM_ACC_W:0] acc;
   logic [`QDCS_DSM_ACC_W+1:0] accSum;
   logic [`QDCS_INT_W:0] ratio;

   // ========================================================================
   // Accumulator
   // One extra low bit is always added as 1, so each step adds 2*frac + 1 out
   // of 2^19 and the average carry rate is exactly (frac + 0.5) / 2^18.
   assign accSum = {1'b0, acc} + {1'b0, dsmPort.feedbackFraction, 1'b1};
   assign dsmPort.divideRatio = ratio;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         acc <= '0;
         ratio <= '0;
      end
      else
      begin
         acc <= accSum[`QDCS_DSM_ACC_W:0];
         ratio <= {1'b0, dsmPort.feedbackInteger} + {7'h00, accSum[`QDCS_DSM_ACC_W+1]};
      end
   end
endmodule

// *** verilog/qdcs_dsm_if.sv ***
// Interface joining the top module and its delta-sigma modulator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`include "qdcs_defines.svh"

interface qdcs_dsm_if;
   logic [`QDCS_INT_W-1:0] feedbackInteger;
   logic [`QDCS_FRAC_W-1:0] feedbackFraction;
   logic [`QDCS_INT_W:0] divideRatio;

   modport ctrl
   (
      output feedbackInteger,
      output feedbackFraction,
      input divideRatio
   );
   modport dsm
   (
      input feedbackInteger,
      input feedbackFraction,
      output divideRatio
   );
endinterface

// *** verilog/qdcs_pkg.sv ***
// Types for the quad divider configuration select block.
// Assumes qdcs_defines.svh is on the include path.
`include "qdcs_defines.svh"

package qdcs_pkg;
   typedef struct packed
   {
      logic [`QDCS_PRE_W-1:0] preDiv;
      logic [`QDCS_INT_W-1:0] feedbackInteger;
      logic [`QDCS_FRAC_W-1:0] feedbackFraction;
      logic [`QDCS_POST_W-1:0] postDiv;
   } qdcs_set_t;

   typedef enum logic [1:0] {QDCS_IDLE, QDCS_ADDR, QDCS_DATA, QDCS_RDBK} qdcs_state_t;
endpackage
